/* sfr_regs.vh */
// sfr_regs.vh: opcodes, id fields and timing counts for the serial fram slave
// assumes: included by bare name by the sfr design files
`ifndef SFR_REGS_VH
`define SFR_REGS_VH
// ----------------------------------------
// opcodes
// ----------------------------------------
`define SFR_OP_FAST_READ 8'h0b
`define SFR_OP_SLEEP 8'hb9
`define SFR_OP_IDENT 8'h9f
// ----------------------------------------
// address and array layout
// ----------------------------------------
`define SFR_ADDR_W 18
`define SFR_ADDR_LAST 18'h3ffff
`define SFR_ROW_W 15
`define SFR_ROW_BYTES 8
// ----------------------------------------
// identification (arbitrary neutral values)
// ----------------------------------------
`define SFR_ID_BYTES 9
`define SFR_ID_CONT_BYTES 6
`define SFR_ID_CONT 8'h5a
`define SFR_ID_MAKER 8'h3c
`define SFR_ID_FAMILY 3'h2
`define SFR_ID_DENSITY 5'h06
`define SFR_ID_SUB 2'h2
`define SFR_ID_REV 3'h3
`define SFR_ID_RSVD 3'h0
// ----------------------------------------
// timing
// ----------------------------------------
`define SFR_CLK_MHZ 250
`define SFR_WAKE_US 400
`define SFR_WAKE_CYCLES (`SFR_WAKE_US * `SFR_CLK_MHZ)
`endif

/* sfr_sync.v */
// sfr_sync.v: two flip-flop synchroniser for one pin level
// assumes: input is asynchronous to clock
`timescale 1ns/1ps
module sfr_sync #(
   parameter RESET_VAL = 1'b0
) (
   clock,
   rst,
   pin,
   level
);
   input wire clock;
   input wire rst;
   input wire pin;
   output reg level;
   reg meta_q;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_q <= RESET_VAL;
         level <= RESET_VAL;
      end else begin
         meta_q <= pin;
         level <= meta_q;
      end
   end
endmodule

/* sfr_array.v */
// sfr_array.v: storage array, one 64-bit row read per access
// assumes: row address held stable while rd_en pulses; data valid next cycle
`timescale 1ns/1ps
`include "sfr_regs.vh"
module sfr_array #(
   parameter ROW_W = `SFR_ROW_W
) (
   clock,
   rd_en,
   row,
   row_data,
   wr_en,
   wr_row,
   wr_data
);
   input wire clock;
   input wire rd_en;
   input wire [ROW_W-1:0] row;
   output reg [63:0] row_data;
   input wire wr_en;
   input wire [ROW_W-1:0] wr_row;
   input wire [63:0] wr_data;
   reg [63:0] mem [0:(1<<ROW_W)-1];
   // ----------------------------------------
   // whole row access
   // ----------------------------------------
   always @(posedge clock) begin
      if (wr_en) begin
         mem[wr_row] <= wr_data;
      end
      if (rd_en) begin
         row_data <= mem[row];
      end
   end
endmodule

/* sfr_slave.v */
// sfr_slave.v: spi slave for fast read, sleep and identification commands
// assumes: spi mode 0 or 3 master; sck, cs_n and si asynchronous pins
// Functional notes
// [RL1] opcode 0x0b selects fast read
// [RL2] fast read carries three address bytes then one dummy byte
// [RL3] dummy byte delays read data by eight sck cycles
// [RL4] data bytes shift out msb first while selected and clocked
// [RL5] address steps after each byte, wrapping from last to zero
// [RL6] serial input ignored while read data is driven
// [RL7] chip select rising ends fast read, output goes high impedance
// [RL8] sleep entered only after opcode 0xb9 then chip select rise
// [RL9] sleep ignores sck and si, output high impedance, watches select
// [RL10] first select fall in sleep starts wake, done within recovery time
// [RL11] output stays high impedance and opcodes ignored during wake
// [RL12] master should send throwaway transaction then wait out recovery
// [RL13] opcode 0x9f returns nine read-only identification bytes
// [RL14] six continuation bytes then maker byte precede product bytes
// [RL15] product bytes hold family, density, sub, revision, reserved fields
// [RL16] array is 32k rows of 64 bits, one row access per row
// [RL17] upper six address bits ignored, low 18 bits used
// [RL18] si sampled on sck rise, so updated on sck fall
`timescale 1ns/1ps
`include "sfr_regs.vh"
module sfr_slave #(
   parameter WAKE_CYCLES = `SFR_WAKE_CYCLES
) (
   clock,
   rst,
   sck,
   cs_n,
   si,
   so_o,
   so_oe,
   asleep,
   wr_en,
   wr_row,
   wr_data
);
   input wire clock;
   input wire rst;
   input wire sck;
   input wire cs_n;
   input wire si;
   output reg so_o;
   output reg so_oe;
   output wire asleep;
   input wire wr_en;
   input wire [`SFR_ROW_W-1:0] wr_row;
   input wire [63:0] wr_data;

   localparam ST_OPC = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_DUMMY = 3'd2;
   localparam ST_READ = 3'd3;
   localparam ST_IDENT = 3'd4;
   localparam ST_IGNORE = 3'd5;
   localparam ST_SLEEP = 3'd6;
   localparam ST_WAKE = 3'd7;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   wire sck_s;
   wire cs_n_s;
   wire si_s;
   sfr_sync #(.RESET_VAL(1'b0)) u_sck (
      .clock(clock),
      .rst(rst),
      .pin(sck),
      .level(sck_s)
   );
   // select idles high so no false select edge follows reset
   sfr_sync #(.RESET_VAL(1'b1)) u_cs (
      .clock(clock),
      .rst(rst),
      .pin(cs_n),
      .level(cs_n_s)
   );
   sfr_sync #(.RESET_VAL(1'b0)) u_si (
      .clock(clock),
      .rst(rst),
      .pin(si),
      .level(si_s)
   );

   // ----------------------------------------
   // pin edge detection
   // ----------------------------------------
   reg sck_q;
   reg cs_n_q;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         sck_q <= 1'b0;
         cs_n_q <= 1'b1;
      end else begin
         sck_q <= sck_s;
         cs_n_q <= cs_n_s;
      end
   end
   wire sck_rise = sck_s & ~sck_q;
   wire sck_fall = ~sck_s & sck_q;
   wire cs_fall = ~cs_n_s & cs_n_q;
   wire cs_rise = cs_n_s & ~cs_n_q;
   wire sel = ~cs_n_s;

   // ----------------------------------------
   // identification byte lookup
   // ----------------------------------------
   function [7:0] id_byte;
      input [3:0] idx;
      begin
         if (idx < `SFR_ID_CONT_BYTES)
            id_byte = `SFR_ID_CONT; // RL14
         else if (idx == `SFR_ID_CONT_BYTES)
            id_byte = `SFR_ID_MAKER; // RL14
         else if (idx == `SFR_ID_CONT_BYTES + 1)
            id_byte = {`SFR_ID_FAMILY, `SFR_ID_DENSITY}; // RL15
         else
            id_byte = {`SFR_ID_SUB, `SFR_ID_REV, `SFR_ID_RSVD}; // RL15
      end
   endfunction

   // read address step; wraps from the top of the array to zero
   function [`SFR_ADDR_W-1:0] next_addr;
      input [`SFR_ADDR_W-1:0] a;
      begin
         if (a == `SFR_ADDR_LAST)
            next_addr = {`SFR_ADDR_W{1'b0}}; // RL5
         else
            next_addr = a + 18'h00001; // RL5
      end
   endfunction

   // ----------------------------------------
   // storage array
   // ----------------------------------------
   reg [`SFR_ADDR_W-1:0] addr_q;
   reg arr_rd_q;
   wire [63:0] row_data;
   sfr_array #(.ROW_W(`SFR_ROW_W)) u_array (
      .clock(clock),
      .rd_en(arr_rd_q),
      .row(addr_q[`SFR_ADDR_W-1:3]),
      .row_data(row_data),
      .wr_en(wr_en),
      .wr_row(wr_row),
      .wr_data(wr_data)
   ); // RL16

   // ----------------------------------------
   // command state machine
   // ----------------------------------------
   reg [2:0] state_q;
   reg [7:0] shin_q;
   reg [2:0] bit_q;
   reg [1:0] abyte_q;
   reg [7:0] shout_q;
   reg [3:0] idx_q;
   reg sleep_cmd_q;
   reg [31:0] wake_q;
   reg row_ok_q;
   reg row_wait_q;
   wire [7:0] in_byte = {shin_q[6:0], si_s};
   wire byte_done = sck_rise & (bit_q == 3'd7);
   wire [7:0] cur_byte = row_data[(7 - addr_q[2:0]) * 8 +: 8];

   assign asleep = (state_q == ST_SLEEP) | (state_q == ST_WAKE);

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q <= ST_OPC;
         shin_q <= 8'h00;
         bit_q <= 3'd0;
         abyte_q <= 2'd0;
         shout_q <= 8'h00;
         idx_q <= 4'h0;
         sleep_cmd_q <= 1'b0;
         wake_q <= 32'h0;
         addr_q <= {`SFR_ADDR_W{1'b0}};
         arr_rd_q <= 1'b0;
         row_ok_q <= 1'b0;
         row_wait_q <= 1'b0;
         so_o <= 1'b0;
         so_oe <= 1'b0;
      end else begin
         arr_rd_q <= 1'b0;
         // a stepped address needs one cycle for the row read, one more for the byte
         row_ok_q <= row_wait_q;
         row_wait_q <= 1'b0;
         case (state_q)
            ST_SLEEP: begin
               // sck and si are not looked at while asleep
               so_oe <= 1'b0; // RL9
               if (cs_fall) begin
                  wake_q <= 32'h0;
                  state_q <= ST_WAKE; // RL10
               end
            end
            ST_WAKE: begin
               so_oe <= 1'b0; // RL11
               wake_q <= wake_q + 32'h1;
               if (wake_q >= WAKE_CYCLES - 1) begin
                  // opcodes sent during wake are dropped; resume at next select
                  state_q <= sel ? ST_IGNORE : ST_OPC; // RL10 RL12
               end
            end
            default: begin
               if (cs_rise | ~sel) begin
                  so_oe <= 1'b0; // RL7
                  bit_q <= 3'd0;
                  abyte_q <= 2'd0;
                  if (cs_rise & sleep_cmd_q) begin
                     state_q <= ST_SLEEP; // RL8
                  end else begin
                     state_q <= ST_OPC;
                  end
                  sleep_cmd_q <= 1'b0;
               end else begin
                  if (sck_rise) begin
                     bit_q <= bit_q + 3'd1;
                     shin_q <= in_byte; // RL18
                  end
                  case (state_q)
                     ST_OPC: begin
                        if (byte_done) begin
                           if (in_byte == `SFR_OP_FAST_READ) begin
                              state_q <= ST_ADDR; // RL1
                           end else if (in_byte == `SFR_OP_IDENT) begin
                              idx_q <= 4'h0;
                              shout_q <= id_byte(4'h0);
                              state_q <= ST_IDENT; // RL13
                           end else if (in_byte == `SFR_OP_SLEEP) begin
                              sleep_cmd_q <= 1'b1; // RL8
                              state_q <= ST_IGNORE;
                           end else begin
                              state_q <= ST_IGNORE;
                           end
                        end
                     end
                     ST_ADDR: begin
                        if (byte_done) begin
                           // upper six bits of the first byte fall off the top
                           addr_q <= {addr_q[9:0], in_byte}; // RL17
                           abyte_q <= abyte_q + 2'd1;
                           if (abyte_q == 2'd2) begin
                              state_q <= ST_DUMMY; // RL2
                              arr_rd_q <= 1'b1;
                           end
                        end
                     end
                     ST_DUMMY: begin
                        // the start row was fetched during the dummy byte
                        if (byte_done) begin
                           shout_q <= cur_byte; // RL3
                           state_q <= ST_READ;
                        end
                     end
                     ST_READ: begin
                        // si is not looked at while streaming data
                        if (sck_fall) begin
                           so_oe <= 1'b1;
                           so_o <= shout_q[7]; // RL4 RL6
                           shout_q <= {shout_q[6:0], 1'b0};
                        end
                        // next byte taken two cycles after each address step, whether or not the row was read again
                        if (row_ok_q) begin
                           shout_q <= cur_byte;
                        end
                        if (byte_done) begin
                           addr_q <= next_addr(addr_q); // RL5
                           // the row is fetched again only when the step leaves it
                           arr_rd_q <= (addr_q[2:0] == 3'd7); // RL16
                           row_wait_q <= 1'b1;
                        end
                     end
                     ST_IDENT: begin
                        if (sck_fall) begin
                           so_oe <= 1'b1;
                           so_o <= shout_q[7]; // RL13
                           shout_q <= {shout_q[6:0], 1'b0};
                        end
                        if (byte_done) begin
                           if (idx_q == `SFR_ID_BYTES - 1) begin
                              state_q <= ST_IGNORE;
                           end else begin
                              idx_q <= idx_q + 4'h1;
                              shout_q <= id_byte(idx_q + 4'h1); // RL14
                           end
                        end
                     end
                     default: begin
                        if (sck_fall)
                           so_oe <= 1'b0;
                     end
                  endcase
               end
            end
         endcase
      end
   end
endmodule

/* sfr_slave_asserts.sv */
// sfr_slave_asserts.sv: port checker for the serial fram slave
// assumes: bound to sfr_slave, mode 0 host with sck far slower than clock
`timescale 1ns/1ps
module sfr_slave_asserts #(
   parameter WAKE_CYCLES = 50
) (
   input wire clock,
   input wire rst,
   input wire sck,
   input wire cs_n,
   input wire so_o,
   input wire so_oe,
   input wire asleep
);
   localparam int WAKE_MAX = WAKE_CYCLES + 16;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_wake_start;
      asleep && !cs_n;
   endsequence
   sequence s_awake;
      ##[1:WAKE_MAX] !asleep;
   endsequence
   a_wake_bound: assert property (s_wake_start |-> s_awake)
      else $error("wake not finished in time");
   a_sleep_quiet: assert property (asleep [*2] |-> !so_oe)
      else $error("output driven while asleep");
   a_wake_no_out: assert property ($fell(asleep) |-> !so_oe [*4])
      else $error("output driven right after wake");
   a_cs_rise_hiz: assert property (cs_n [*6] |-> !so_oe)
      else $error("output driven while deselected");
   a_oe_after_sel: assert property ($rose(so_oe) |-> !cs_n && !$past(cs_n, 8))
      else $error("output enabled without select");
   a_so_on_fall: assert property (so_oe && $past(so_oe) && $changed(so_o) |-> !sck)
      else $error("output changed while sck high");
   a_sleep_cs_high: assert property ($rose(asleep) |-> cs_n)
      else $error("sleep entered while selected");
   a_sleep_entry: assert property ($rose(asleep) |-> !$past(cs_n, 16))
      else $error("sleep entered without a command");
endmodule

/* sfr_spi_host.sv */
// sfr_spi_host.sv: behavioural spi mode 0 host, sck period 16 clocks
// assumes: tasks are called just after a rising clock edge
`timescale 1ns/1ps
module sfr_spi_host (
   input wire clock,
   input wire so_o,
   input wire so_oe,
   output reg sck,
   output reg cs_n,
   output reg si
);
   reg last_q;
   // a released line shows the inverse of its last driven value
   wire so_w = so_oe ? so_o : ~last_q;
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      last_q = 1'b0;
   end
   always @(posedge clock) begin
      if (so_oe) last_q <= so_o;
   end
   task sel(input logic v);
      cs_n <= v;
      repeat (8) @(posedge clock);
   endtask
   // si set while sck low, so read just before the rise
   task xbyte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         si <= tx[i];
         repeat (8) @(posedge clock);
         rx[i] = so_w;
         sck <= 1'b1;
         repeat (8) @(posedge clock);
         sck <= 1'b0;
      end
   endtask
endmodule

/* tb_serial_fram_fastread_sleep_id.sv */
// tb_serial_fram_fastread_sleep_id.sv: self-checking bench for sfr_slave
// assumes: sfr_spi_host as bus master, array preloaded through backdoor
`timescale 1ns/1ps
`include "sfr_regs.vh"
module tb_serial_fram_fastread_sleep_id;
   typedef struct packed {logic [23:0] a; int n; logic [7:0] first;} sfr_row_t;
   localparam int WAKE = 50;
   reg clock, rst, wr_en;
   reg [14:0] wr_row;
   reg [63:0] wr_data;
   wire sck, cs_n, si, so_o, so_oe, asleep;
   int n_errors = 0, n_tests = 0;
   logic [7:0] rx;
   logic [15:0] prod;
   sfr_row_t rows [3];
   sfr_slave #(.WAKE_CYCLES(WAKE)) dut_u (.clock(clock), .rst(rst), .sck(sck), .cs_n(cs_n),
      .si(si), .so_o(so_o), .so_oe(so_oe), .asleep(asleep), .wr_en(wr_en), .wr_row(wr_row),
      .wr_data(wr_data));
   sfr_spi_host host_u (.clock(clock), .so_o(so_o), .so_oe(so_oe), .sck(sck), .cs_n(cs_n),
      .si(si));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   function automatic logic [7:0] pat(input logic [17:0] a);
      return a[7:0] ^ 8'ha5;
   endfunction
   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task complete_run;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task load(input logic [14:0] r);
      @(posedge clock);
      for (int k = 0; k < 8; k++) wr_data[63 - 8 * k -: 8] <= pat({r, k[2:0]});
      wr_row <= r;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask
   task fr(input sfr_row_t t);
      host_u.sel(1'b0);
      host_u.xbyte(`SFR_OP_FAST_READ, rx);
      for (int b = 2; b >= 0; b--) host_u.xbyte(t.a[8 * b +: 8], rx);
      host_u.xbyte(8'h00, rx);
      for (int k = 0; k < t.n; k++) begin
         host_u.xbyte(8'hc3 ^ k[7:0], rx);
         if (k == 0) chk("first byte", rx, t.first);
         else chk("next byte", rx, pat(t.a[17:0] + k[17:0]));
      end
      host_u.sel(1'b1);
      chk("oe after deselect", {7'h0, so_oe}, 8'h00);
      $display("fast read at %h done", t.a);
   endtask
   initial begin
      rows = '{'{24'h000000, 2, 8'ha5}, '{24'hfc0006, 3, 8'ha3}, '{24'h03fffe, 3, 8'h5b}};
      prod = {`SFR_ID_FAMILY, `SFR_ID_DENSITY, `SFR_ID_SUB, `SFR_ID_REV, `SFR_ID_RSVD};
      rst <= 1'b1;
      wr_en <= 1'b0;
      wr_row <= 15'h0000;
      wr_data <= 64'h0;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      load(15'h0000);
      load(15'h0001);
      load(15'h7fff);
      repeat (8) @(posedge clock);
      foreach (rows[i]) fr(rows[i]);
      host_u.sel(1'b0);
      host_u.xbyte(`SFR_OP_IDENT, rx);
      for (int i = 0; i < 9; i++) begin
         host_u.xbyte(8'hff, rx);
         chk("id byte", rx, i < 6 ? `SFR_ID_CONT : i == 6 ? `SFR_ID_MAKER :
            i == 7 ? prod[15:8] : prod[7:0]);
      end
      host_u.sel(1'b1);
      $display("identification done");
      host_u.sel(1'b0);
      host_u.xbyte(`SFR_OP_SLEEP, rx);
      host_u.sel(1'b1);
      chk("asleep", {7'h0, asleep}, 8'h01);
      host_u.xbyte(`SFR_OP_FAST_READ, rx);
      chk("asleep with sck", {7'h0, asleep}, 8'h01);
      host_u.sel(1'b0);
      chk("asleep in wake", {7'h0, asleep}, 8'h01);
      chk("oe in wake", {7'h0, so_oe}, 8'h00);
      host_u.xbyte(`SFR_OP_IDENT, rx);
      host_u.xbyte(8'hff, rx);
      chk("oe in wake select", {7'h0, so_oe}, 8'h00);
      host_u.sel(1'b1);
      for (int w = 0; w < 4 * WAKE && asleep !== 1'b0; w++) @(posedge clock);
      chk("awake", {7'h0, asleep}, 8'h00);
      if (asleep !== 1'b0) complete_run();
      fr(rows[0]);
      $display("sleep and wake done");
      host_u.sel(1'b0);
      host_u.xbyte(`SFR_OP_FAST_READ, rx);
      repeat (4) host_u.xbyte(8'h00, rx);
      repeat (12) @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      chk("reset oe", {7'h0, so_oe}, 8'h00);
      chk("reset asleep", {7'h0, asleep}, 8'h00);
      @(posedge clock);
      rst <= 1'b0;
      host_u.sel(1'b1);
      fr(rows[2]);
      $display("reset mid read done");
      complete_run();
   end
endmodule
bind sfr_slave sfr_slave_asserts #(.WAKE_CYCLES(WAKE_CYCLES)) chk_u (.clock(clock), .rst(rst),
   .sck(sck), .cs_n(cs_n), .so_o(so_o), .so_oe(so_oe), .asleep(asleep));
